// File: logic/mfr_cfg.svh
`ifndef MFR_CFG_SVH
`define MFR_CFG_SVH
// Register byte offsets
`define MFR_CTRL_ADDR       8'h00
`define MFR_CMD_ADDR        8'h04
`define MFR_STATUS_ADDR     8'h08
`define MFR_CTRL_RST        32'h0000_0000
// Control field positions
`define MFR_ILIM_SEL_LSB    0
`define MFR_MTR_SEL_LSB     4
`define MFR_DEG_SEL_LSB     8
`define MFR_RETRY_SEL_LSB   11
`define MFR_PIN_DIS_BIT     14
`define MFR_WARN_REP_BIT    15
`define MFR_LOCK_EN_LSB     16
`define MFR_CLR_BIT         0
// Status field positions
`define MFR_ST_CTRL_FLT     0
`define MFR_ST_ILIM         1
`define MFR_ST_MTR          2
`define MFR_ST_DRV_FLT      3
`define MFR_ST_OT           4
`define MFR_ST_WARN         5
`define MFR_ST_TSD          6
`define MFR_ST_ALERT        7
`define MFR_ST_LOCK_LSB     16
// Timing
`define MFR_CLK_NS          50
`define MFR_BUCK_DEG_NS     2000
`define MFR_BUCK_DEG_CYC    ((`MFR_BUCK_DEG_NS + `MFR_CLK_NS - 1) / `MFR_CLK_NS)
`define MFR_DEG_UNIT_NS     1000
`define MFR_DEG_UNIT_CYC    ((`MFR_DEG_UNIT_NS + `MFR_CLK_NS - 1) / `MFR_CLK_NS)
`define MFR_RETRY_UNIT_MS   100
`define MFR_RETRY_UNIT_CYC  (`MFR_RETRY_UNIT_MS * 1000000 / `MFR_CLK_NS)
`endif

// File: logic/mfr_pkg.sv
package mfr_pkg;
	typedef enum logic [3:0] {
		FLT_IDLE   = 4'h1,
		FLT_LATCH  = 4'h2,
		FLT_RETRY  = 4'h4,
		FLT_REPORT = 4'h8
	} mfr_flt_e;
	typedef enum logic [4:0] {
		STG_DRIVE  = 5'h01,
		STG_OFF    = 5'h02,
		STG_RECIRC = 5'h04,
		STG_HS_ON  = 5'h08,
		STG_LS_ON  = 5'h10
	} mfr_stage_e;
	typedef enum logic [1:0] {
		RSP_LATCH  = 2'h0,
		RSP_RETRY  = 2'h1,
		RSP_REPORT = 2'h2,
		RSP_NONE   = 2'h3
	} mfr_rsp_e;
endpackage

// File: logic/mfr_fault_ctrl.sv
// Register access over Wishbone and the address map are this design's own decisions.
`timescale 1ns/1ns
`include "mfr_cfg.svh"
module mfr_fault_ctrl
	import mfr_pkg::*;
#(
	parameter int AW             = 8,
	parameter int TW             = 26,
	parameter int NLOCK          = 3,
	parameter int DEG_UNIT_CYC   = `MFR_DEG_UNIT_CYC,
	parameter int RETRY_UNIT_CYC = `MFR_RETRY_UNIT_CYC
) (
	// Clock and reset
	input  wire logic             clk_i,
	input  wire logic             rst_i,
	// Wishbone slave
	input  wire logic             cyc_i,
	input  wire logic             stb_i,
	input  wire logic             we_i,
	input  wire logic [AW-1:0]    adr_i,
	input  wire logic [3:0]       sel_i,
	input  wire logic [31:0]      dat_i,
	output logic      [31:0]      dat_o,
	output logic                  ack_o,
	// Analog comparator pins
	input  wire logic             buck_ocp_i,
	input  wire logic             current_sense_amp_over_i,
	input  wire logic             temp_warn_i,
	input  wire logic             temp_warn_hys_i,
	input  wire logic             temp_tsd_i,
	input  wire logic             temp_tsd_hys_i,
	input  wire logic             recirc_done_i,
	// Motor lock detectors, same clock
	input  wire logic             motor_running_i,
	input  wire logic [NLOCK-1:0] lock_cond_i,
	// Power stage and alert
	output logic                  alert_out_n_o,
	output mfr_stage_e            stage_o,
	output logic                  charge_pump_en_o,
	output logic                  buck_reset_o
);
	localparam int NS = 7;

	if (NLOCK < 1 || NLOCK > 16 || DEG_UNIT_CYC < 1 || RETRY_UNIT_CYC < 1 ||
		longint'(RETRY_UNIT_CYC) * 8 >= (longint'(1) << TW) || DEG_UNIT_CYC * 8 > 65535) begin : g_chk
		$error("mfr_fault_ctrl: parameters out of range");
	end

	function automatic mfr_rsp_e rsp_of(input logic [3:0] s);
		if (!s[3])
			return s[2] ? RSP_RETRY : RSP_LATCH;
		return (s == 4'h8) ? RSP_REPORT : RSP_NONE;
	endfunction

	function automatic mfr_stage_e stage_of(input logic [1:0] lo, input logic done);
		case (lo)
			2'h0:    return STG_OFF;
			2'h1:    return done ? STG_OFF : STG_RECIRC;
			2'h2:    return STG_HS_ON;
			default: return STG_LS_ON;
		endcase
	endfunction

	function automatic mfr_flt_e flt_step(input mfr_flt_e st, input logic ev, input logic cond,
		input logic [3:0] s, input logic clr, input logic done);
		case (st)
			FLT_IDLE: begin
				if (!ev)
					return FLT_IDLE;
				case (rsp_of(s))
					RSP_LATCH:  return FLT_LATCH;
					RSP_RETRY:  return FLT_RETRY;
					RSP_REPORT: return FLT_REPORT;
					default:    return FLT_IDLE;
				endcase
			end
			FLT_LATCH, FLT_REPORT:
				return (clr && !cond) ? FLT_IDLE : st;
			FLT_RETRY:
				return done ? FLT_IDLE : FLT_RETRY;
			default:
				return FLT_IDLE;
		endcase
	endfunction

	function automatic logic [15:0] deg_step(input logic [15:0] c, input logic lvl, input logic [15:0] lim);
		if (!lvl)
			return 16'h0000;
		return (c < lim) ? c + 16'h0001 : c;
	endfunction

	function automatic logic [TW-1:0] retry_cyc(input logic [2:0] s);
		return TW'((int'(s) + 1) * RETRY_UNIT_CYC);
	endfunction

	function automatic logic [TW-1:0] tmr_step(input mfr_flt_e st, input mfr_flt_e nx,
		input logic [TW-1:0] t, input logic [2:0] s);
		if (st == FLT_IDLE && nx == FLT_RETRY)
			return retry_cyc(s) - TW'(1);
		return (st == FLT_RETRY && t != '0) ? t - TW'(1) : t;
	endfunction

	// Pin synchronisers: a change counts once stages two and three agree
	logic [NS-1:0] s1_reg, s2_reg, s3_reg, pin_reg;
	logic [NS-1:0] s1_next, s2_next, s3_next, pin_next;
	logic          p_buck, p_csa, p_warn, p_warn_hys, p_tsd, p_tsd_hys, p_done;

	always_comb begin
		s1_next  = {recirc_done_i, temp_tsd_hys_i, temp_tsd_i, temp_warn_hys_i, temp_warn_i,
			current_sense_amp_over_i, buck_ocp_i};
		s2_next  = s1_reg;
		s3_next  = s2_reg;
		pin_next = (s2_reg & s3_reg) | (pin_reg & (s2_reg | s3_reg));
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s1_reg  <= '0;
			s2_reg  <= '0;
			s3_reg  <= '0;
			pin_reg <= '0;
		end else begin
			s1_reg  <= s1_next;
			s2_reg  <= s2_next;
			s3_reg  <= s3_next;
			pin_reg <= pin_next;
		end
	end
	assign {p_done, p_tsd_hys, p_tsd, p_warn_hys, p_warn, p_csa, p_buck} = pin_reg;

	// Buck overcurrent: the block resets itself, as its supply is collapsing
	logic [15:0] buck_cnt_reg, buck_cnt_next;
	logic        buck_rst_reg, buck_rst_next;
	logic        rst_int;

	always_comb begin
		buck_cnt_next = deg_step(buck_cnt_reg, p_buck, 16'(`MFR_BUCK_DEG_CYC));
		buck_rst_next = p_buck && buck_cnt_reg == 16'(`MFR_BUCK_DEG_CYC - 1);
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			buck_cnt_reg <= 16'h0000;
			buck_rst_reg <= 1'b0;
		end else begin
			buck_cnt_reg <= buck_cnt_next;
			buck_rst_reg <= buck_rst_next;
		end
	end
	assign rst_int      = rst_i | buck_rst_reg;
	assign buck_reset_o = buck_rst_reg;

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_int);

	a_buck_reset: assert property (disable iff (rst_i)
		$rose(buck_rst_reg) |-> $past(p_buck) && $past(buck_cnt_reg) == 16'(`MFR_BUCK_DEG_CYC - 1))
		else $error("buck reset without full deglitch");

	// Register file
	logic [31:0]    ctrl_reg, ctrl_next, dat_reg, dat_next, status_w;
	logic           ack_reg, ack_next, clr_reg, clr_next, req;
	logic [3:0]     ilim_sel, mtr_sel;
	logic [2:0]     deg_sel, retry_sel;
	logic           pin_dis, warn_rep;
	logic [NLOCK-1:0] lock_en;

	assign ilim_sel  = ctrl_reg[`MFR_ILIM_SEL_LSB +: 4];
	assign mtr_sel   = ctrl_reg[`MFR_MTR_SEL_LSB +: 4];
	assign deg_sel   = ctrl_reg[`MFR_DEG_SEL_LSB +: 3];
	assign retry_sel = ctrl_reg[`MFR_RETRY_SEL_LSB +: 3];
	assign pin_dis   = ctrl_reg[`MFR_PIN_DIS_BIT];
	assign warn_rep  = ctrl_reg[`MFR_WARN_REP_BIT];
	assign lock_en   = ctrl_reg[`MFR_LOCK_EN_LSB +: NLOCK];

	always_comb begin
		req       = cyc_i && stb_i && !ack_reg;
		ack_next  = req;
		ctrl_next = ctrl_reg;
		dat_next  = dat_reg;
		clr_next  = 1'b0;
		if (req && we_i) begin
			if (adr_i == AW'(`MFR_CTRL_ADDR)) begin
				for (int b = 0; b < 4; b++) begin
					if (sel_i[b])
						ctrl_next[b*8 +: 8] = dat_i[b*8 +: 8];
				end
			end
			clr_next = adr_i == AW'(`MFR_CMD_ADDR) && sel_i[0] && dat_i[`MFR_CLR_BIT];
		end else if (req) begin
			if (adr_i == AW'(`MFR_CTRL_ADDR))
				dat_next = ctrl_reg;
			else if (adr_i == AW'(`MFR_STATUS_ADDR))
				dat_next = status_w;
			else
				dat_next = 32'h0000_0000;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_int) begin
			ctrl_reg <= `MFR_CTRL_RST;
			dat_reg  <= 32'h0000_0000;
			ack_reg  <= 1'b0;
			clr_reg  <= 1'b0;
		end else begin
			ctrl_reg <= ctrl_next;
			dat_reg  <= dat_next;
			ack_reg  <= ack_next;
			clr_reg  <= clr_next;
		end
	end
	assign dat_o = dat_reg;
	assign ack_o = ack_reg;

	// Current-limit lock; deglitch restarts once a response ends so a standing fault re-triggers
	mfr_flt_e      ilim_st_reg, ilim_st_next;
	logic [15:0]   ilim_cnt_reg, ilim_cnt_next, ilim_lim;
	logic [TW-1:0] ilim_tmr_reg, ilim_tmr_next;
	logic          ilim_ev;

	always_comb begin
		ilim_lim      = 16'((int'(deg_sel) + 1) * DEG_UNIT_CYC);
		ilim_ev       = p_csa && ilim_cnt_reg == ilim_lim - 16'h0001;
		ilim_cnt_next = (ilim_st_reg != FLT_IDLE) ? 16'h0000 : deg_step(ilim_cnt_reg, p_csa, ilim_lim);
		ilim_st_next  = flt_step(ilim_st_reg, ilim_ev, p_csa, ilim_sel, clr_reg, ilim_tmr_reg == '0);
		ilim_tmr_next = tmr_step(ilim_st_reg, ilim_st_next, ilim_tmr_reg, retry_sel);
	end

	always_ff @(posedge clk_i) begin
		if (rst_int) begin
			ilim_st_reg  <= FLT_IDLE;
			ilim_cnt_reg <= 16'h0000;
			ilim_tmr_reg <= '0;
		end else begin
			ilim_st_reg  <= ilim_st_next;
			ilim_cnt_reg <= ilim_cnt_next;
			ilim_tmr_reg <= ilim_tmr_next;
		end
	end

	a_ilim_deglitch: assert property (
		ilim_st_reg == FLT_IDLE && ilim_st_next != FLT_IDLE |-> p_csa && ilim_cnt_reg == ilim_lim - 16'h0001)
		else $error("current-limit event before deglitch");
	a_ilim_mode: assert property (
		ilim_st_reg == FLT_IDLE && ilim_ev && ilim_sel[3] && ilim_sel[0] |=> ilim_st_reg == FLT_IDLE)
		else $error("disabled current-limit mode responded");
	a_ilim_latch: assert property (
		ilim_st_reg == FLT_LATCH && (p_csa || !clr_reg) |=> ilim_st_reg == FLT_LATCH && !alert_out_n_o)
		else $error("latched current-limit left early");
	a_ilim_retry: assert property (
		ilim_st_reg == FLT_RETRY && ilim_tmr_reg != '0 |=> ilim_st_reg == FLT_RETRY)
		else $error("retry ended before its time");
	a_ilim_report: assert property (
		ilim_st_reg == FLT_REPORT && !pin_dis && !$past(rst_int) |=> !alert_out_n_o)
		else $error("report mode did not pull alert");

	// Motor lock
	mfr_flt_e         mtr_st_reg, mtr_st_next;
	logic [TW-1:0]    mtr_tmr_reg, mtr_tmr_next;
	logic [NLOCK-1:0] lockf_reg, lockf_next, hits;
	logic             mtr_ev;

	always_comb begin
		hits         = lock_cond_i & lock_en;
		mtr_ev       = motor_running_i && |hits;
		mtr_st_next  = flt_step(mtr_st_reg, mtr_ev, |hits, mtr_sel, clr_reg, mtr_tmr_reg == '0);
		mtr_tmr_next = tmr_step(mtr_st_reg, mtr_st_next, mtr_tmr_reg, retry_sel);
		lockf_next   = (mtr_st_next == FLT_IDLE) ? '0 : lockf_reg;
		if (mtr_st_next != FLT_IDLE)
			lockf_next = lockf_next | hits;
	end

	always_ff @(posedge clk_i) begin
		if (rst_int) begin
			mtr_st_reg  <= FLT_IDLE;
			mtr_tmr_reg <= '0;
			lockf_reg   <= '0;
		end else begin
			mtr_st_reg  <= mtr_st_next;
			mtr_tmr_reg <= mtr_tmr_next;
			lockf_reg   <= lockf_next;
		end
	end

	a_mtr_event: assert property (
		mtr_st_reg == FLT_IDLE && motor_running_i && |(lock_cond_i & lock_en) && mtr_sel == 4'h0
		|=> mtr_st_reg == FLT_LATCH && lockf_reg != '0)
		else $error("motor lock not latched");
	a_mtr_retry: assert property (
		mtr_st_reg == FLT_RETRY && mtr_st_next == FLT_IDLE |=> lockf_reg == '0)
		else $error("motor lock flags kept after retry");

	// Thermal warning and shutdown; set wins over a same-cycle clear
	logic tsd_act_reg, warn_pin_reg, warn_f_reg, ot_f_reg, tsd_f_reg, drv_f_reg;
	logic tsd_act_next, warn_pin_next, warn_f_next, ot_f_next, tsd_f_next, drv_f_next;

	always_comb begin
		tsd_act_next  = p_tsd || (tsd_act_reg && !p_tsd_hys);
		warn_pin_next = warn_rep && ((p_warn) || (warn_pin_reg && !p_warn_hys));
		warn_f_next   = p_warn || (warn_f_reg && !clr_reg);
		tsd_f_next    = p_tsd || (tsd_f_reg && !clr_reg);
		ot_f_next     = p_warn || p_tsd || (ot_f_reg && !(clr_reg && !tsd_act_reg));
		drv_f_next    = tsd_act_next || (drv_f_reg && !clr_reg);
	end

	always_ff @(posedge clk_i) begin
		if (rst_int) begin
			tsd_act_reg  <= 1'b0;
			warn_pin_reg <= 1'b0;
			warn_f_reg   <= 1'b0;
			ot_f_reg     <= 1'b0;
			tsd_f_reg    <= 1'b0;
			drv_f_reg    <= 1'b0;
		end else begin
			tsd_act_reg  <= tsd_act_next;
			warn_pin_reg <= warn_pin_next;
			warn_f_reg   <= warn_f_next;
			ot_f_reg     <= ot_f_next;
			tsd_f_reg    <= tsd_f_next;
			drv_f_reg    <= drv_f_next;
		end
	end

	a_warn_alert: assert property (!warn_rep |=> !warn_pin_reg)
		else $error("warning on alert while reporting disabled");
	a_warn_flag: assert property (warn_f_reg && p_warn |=> warn_f_reg)
		else $error("warning flag cleared above limit");
	a_tsd_flag: assert property (tsd_f_reg && !clr_reg |=> tsd_f_reg)
		else $error("shutdown flag dropped without clear");

	// Power stage and alert; thermal shutdown overrides every lock response
	mfr_stage_e stage_reg, stage_next;
	logic       alert_n_reg, alert_n_next, cp_reg, cp_next, ilim_prot, mtr_prot;

	always_comb begin
		ilim_prot = ilim_st_reg == FLT_LATCH || ilim_st_reg == FLT_RETRY;
		mtr_prot  = mtr_st_reg == FLT_LATCH || mtr_st_reg == FLT_RETRY;
		if (tsd_act_reg)
			stage_next = STG_OFF;
		else if (ilim_prot)
			stage_next = stage_of(ilim_sel[1:0], p_done);
		else if (mtr_prot)
			stage_next = stage_of(mtr_sel[1:0], p_done);
		else
			stage_next = STG_DRIVE;
		cp_next      = !tsd_act_reg;
		alert_n_next = !(tsd_act_reg || warn_pin_reg || ilim_prot || mtr_prot ||
			(!pin_dis && (ilim_st_reg == FLT_REPORT || mtr_st_reg == FLT_REPORT)));
	end

	always_ff @(posedge clk_i) begin
		if (rst_int) begin
			stage_reg   <= STG_DRIVE;
			cp_reg      <= 1'b1;
			alert_n_reg <= 1'b1;
		end else begin
			stage_reg   <= stage_next;
			cp_reg      <= cp_next;
			alert_n_reg <= alert_n_next;
		end
	end
	assign stage_o          = stage_reg;
	assign charge_pump_en_o = cp_reg;
	assign alert_out_n_o    = alert_n_reg;

	always_comb begin
		status_w = 32'h0000_0000;
		status_w[`MFR_ST_CTRL_FLT] = ilim_st_reg != FLT_IDLE || mtr_st_reg != FLT_IDLE;
		status_w[`MFR_ST_ILIM]     = ilim_st_reg != FLT_IDLE;
		status_w[`MFR_ST_MTR]      = mtr_st_reg != FLT_IDLE;
		status_w[`MFR_ST_DRV_FLT]  = drv_f_reg;
		status_w[`MFR_ST_OT]       = ot_f_reg;
		status_w[`MFR_ST_WARN]     = warn_f_reg;
		status_w[`MFR_ST_TSD]      = tsd_f_reg;
		status_w[`MFR_ST_ALERT]    = !alert_n_reg;
		status_w[`MFR_ST_LOCK_LSB +: NLOCK] = lockf_reg;
	end

	a_stage_low: assert property (
		ilim_prot && !tsd_act_reg && ilim_sel[1:0] == 2'h3 |=> stage_o == STG_LS_ON)
		else $error("wrong stage for low-side response");
	a_recirc_end: assert property (stage_o == STG_RECIRC |-> !$past(p_done))
		else $error("recirculation held after energy decayed");
	a_tsd_off: assert property (
		tsd_act_reg |=> stage_o == STG_OFF && !charge_pump_en_o && !alert_out_n_o)
		else $error("shutdown did not stop power stage");

	c_ilim_latch: cover property (ilim_st_reg == FLT_LATCH ##1 ilim_st_reg == FLT_IDLE);
	c_ilim_retry: cover property (ilim_st_reg == FLT_RETRY ##1 ilim_st_reg == FLT_IDLE);
	c_mtr_report: cover property (mtr_st_reg == FLT_REPORT && !alert_out_n_o);
	c_tsd_cycle:  cover property (tsd_act_reg ##[1:100] !tsd_act_reg);
endmodule

// File: tb/mfr_host_model.sv
`timescale 1ns/1ns
`include "mfr_cfg.svh"
module mfr_host_model (
	// Clock
	input  wire logic        clk_i,
	// Wishbone master side
	output logic             cyc_o,
	output logic             stb_o,
	output logic             we_o,
	output logic [7:0]       adr_o,
	output logic [3:0]       sel_o,
	output logic [31:0]      dat_o,
	input  wire logic [31:0] dat_i,
	input  wire logic        ack_i
);
	initial begin
		cyc_o = 1'b0;
		stb_o = 1'b0;
		we_o  = 1'b0;
		adr_o = 8'h00;
		sel_o = 4'h0;
		dat_o = 32'h0000_0000;
	end
	// Waits as long as the slave needs; only the bench watchdog ends a hung access
	task automatic access(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
		@(posedge clk_i);
		cyc_o <= 1'b1;
		stb_o <= 1'b1;
		we_o  <= w;
		adr_o <= a;
		sel_o <= 4'hF;
		dat_o <= d;
		@(posedge clk_i);
		while (ack_i !== 1'b1)
			@(posedge clk_i);
		q = dat_i;
		cyc_o <= 1'b0;
		stb_o <= 1'b0;
		// Released data shows the inverse so a stale word never looks valid
		dat_o <= ~d;
	endtask
	// The host handles the condition itself, then leaves the fault with a clear
	task automatic clear_fault();
		logic [31:0] q;
		access(1'b1, `MFR_CMD_ADDR, 32'h0000_0001, q);
	endtask
endmodule

// File: tb/mfr_fault_ctrl_test.sv
`timescale 1ns/1ns
`include "mfr_cfg.svh"
module mfr_fault_ctrl_test;
	import mfr_pkg::*;
	localparam logic [31:0] AL = 32'h0000_0080;
	logic       clk_i, rst_i, cyc, stb, we, ack, alert_n, cp_en, buck_rst;
	logic       buck_ocp, current_sense_amp, warn, warn_hys, thermal_shutdown_flag, tsd_hys, recirc_done, running;
	logic [2:0] lock_cond;
	logic [7:0] adr;
	logic [3:0] sel;
	logic [31:0] wdat, rdat;
	mfr_stage_e stage;
	int         fails = 0, n_compared = 0, n_buck = 0;

	mfr_fault_ctrl #(.DEG_UNIT_CYC(2), .RETRY_UNIT_CYC(20)) u_mfr_fault_ctrl (
		.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
		.sel_i(sel), .dat_i(wdat), .dat_o(rdat), .ack_o(ack), .buck_ocp_i(buck_ocp),
		.current_sense_amp_over_i(current_sense_amp), .temp_warn_i(warn), .temp_warn_hys_i(warn_hys),
		.temp_tsd_i(thermal_shutdown_flag), .temp_tsd_hys_i(tsd_hys), .recirc_done_i(recirc_done),
		.motor_running_i(running), .lock_cond_i(lock_cond), .alert_out_n_o(alert_n),
		.stage_o(stage), .charge_pump_en_o(cp_en), .buck_reset_o(buck_rst));
	mfr_host_model u_mfr_host_model (
		.clk_i(clk_i), .cyc_o(cyc), .stb_o(stb), .we_o(we), .adr_o(adr), .sel_o(sel),
		.dat_o(wdat), .dat_i(rdat), .ack_i(ack));

	initial begin
		clk_i = 1'b0;
		forever #25 clk_i = ~clk_i;
	end
	always @(posedge clk_i) begin
		if (buck_rst === 1'b1)
			n_buck++;
	end

	task automatic test_done();
		$display("compared %0d mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_compared++;
		if (got !== exp) begin
			fails++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		u_mfr_host_model.access(1'b1, a, d, q);
	endtask
	task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] q;
		u_mfr_host_model.access(1'b0, a, 32'h0000_0000, q);
		chk(what, exp, q);
	endtask
	task automatic wait_n(input int n);
		repeat (n) @(posedge clk_i);
	endtask
	task automatic clr();
		u_mfr_host_model.clear_fault();
		wait_n(4);
	endtask
	task automatic chk_out(input logic [4:0] st, input logic al_n, input logic [31:0] status);
		chk("stage", {27'h0, st}, {27'h0, stage});
		chk("alert", {31'h0, al_n}, {31'h0, alert_n});
		rd_chk("status", `MFR_STATUS_ADDR, status);
	endtask
	task automatic trig(input logic mtr, input logic on);
		if (mtr)
			lock_cond[1] <= on;
		else
			current_sense_amp <= on;
	endtask
	// Motor responses use lock condition 1 only, enabled through bit 17
	function automatic logic [31:0] cfg(input logic mtr, input logic [3:0] mode);
		return mtr ? (32'h0002_0000 | {24'h0, mode, 4'h0}) : {28'h0, mode};
	endfunction
	function automatic logic [31:0] flags(input logic mtr);
		return mtr ? 32'h0002_0005 : 32'h0000_0003;
	endfunction
	task automatic latched(input logic mtr, input logic [3:0] mode, input logic [4:0] st);
		wr(`MFR_CTRL_ADDR, cfg(mtr, mode));
		trig(mtr, 1'b1);
		wait_n(12);
		chk_out(st, 1'b0, flags(mtr) | AL);
		clr();
		chk_out(st, 1'b0, flags(mtr) | AL);
		trig(mtr, 1'b0);
		wait_n(8);
		clr();
		chk_out(STG_DRIVE, 1'b1, 32'h0000_0000);
	endtask
	// Retry select 1 gives 2 * 20 cycles, long enough to watch the stage hold
	task automatic retry(input logic mtr, input logic [3:0] mode, input logic [4:0] st);
		wr(`MFR_CTRL_ADDR, cfg(mtr, mode) | 32'h0000_0800);
		trig(mtr, 1'b1);
		wait_n(12);
		chk_out(st, 1'b0, flags(mtr) | AL);
		trig(mtr, 1'b0);
		if (st == STG_RECIRC) begin
			recirc_done <= 1'b1;
			wait_n(6);
			chk_out(STG_OFF, 1'b0, flags(mtr) | AL);
		end
		wait_n(40);
		recirc_done <= 1'b0;
		chk_out(STG_DRIVE, 1'b1, 32'h0000_0000);
	endtask
	task automatic report(input logic mtr, input logic dis);
		wr(`MFR_CTRL_ADDR, cfg(mtr, 4'h8) | {17'h0, dis, 14'h0});
		trig(mtr, 1'b1);
		wait_n(12);
		chk_out(STG_DRIVE, dis, flags(mtr) | (dis ? 32'h0 : AL));
		trig(mtr, 1'b0);
		wait_n(8);
		chk_out(STG_DRIVE, dis, flags(mtr) | (dis ? 32'h0 : AL));
		clr();
		chk_out(STG_DRIVE, 1'b1, 32'h0000_0000);
	endtask
	task automatic quiet(input logic [31:0] ctrl, input logic [2:0] lk, input logic c, input logic run);
		wr(`MFR_CTRL_ADDR, ctrl);
		running   <= run;
		lock_cond <= lk;
		current_sense_amp       <= c;
		wait_n(12);
		chk_out(STG_DRIVE, 1'b1, 32'h0000_0000);
		running   <= 1'b1;
		lock_cond <= 3'b000;
		current_sense_amp       <= 1'b0;
		wait_n(8);
	endtask

	initial begin
		repeat (40000) @(posedge clk_i);
		fails++;
		test_done();
	end
	initial begin
		rst_i = 1'b1;
		{buck_ocp, current_sense_amp, warn, thermal_shutdown_flag, recirc_done} = 5'h00;
		{warn_hys, tsd_hys, running} = 3'h7;
		lock_cond = 3'b000;
		repeat (8) @(posedge clk_i);
		rst_i <= 1'b0;
		chk_out(STG_DRIVE, 1'b1, 32'h0000_0000);
		rd_chk("ctrl", `MFR_CTRL_ADDR, 32'h0000_0000);
		wr(8'h0C, 32'hFFFF_FFFF);
		rd_chk("unmapped", 8'h0C, 32'h0000_0000);
		wr(`MFR_CTRL_ADDR, 32'h0007_FFFF);
		rd_chk("ctrl", `MFR_CTRL_ADDR, 32'h0007_FFFF);
		rd_chk("cmd", `MFR_CMD_ADDR, 32'h0000_0000);
		latched(1'b0, 4'h0, STG_OFF);
		latched(1'b0, 4'h1, STG_RECIRC);
		latched(1'b0, 4'h2, STG_HS_ON);
		latched(1'b0, 4'h3, STG_LS_ON);
		latched(1'b1, 4'h0, STG_OFF);
		latched(1'b1, 4'h2, STG_HS_ON);
		latched(1'b1, 4'h3, STG_LS_ON);
		retry(1'b0, 4'h4, STG_OFF);
		retry(1'b0, 4'h5, STG_RECIRC);
		retry(1'b1, 4'h5, STG_RECIRC);
		retry(1'b1, 4'h6, STG_HS_ON);
		retry(1'b1, 4'h7, STG_LS_ON);
		report(1'b0, 1'b0);
		report(1'b0, 1'b1);
		report(1'b1, 1'b0);
		report(1'b1, 1'b1);
		quiet(32'h0000_0009, 3'b000, 1'b1, 1'b1);
		quiet(32'h0000_000D, 3'b000, 1'b1, 1'b1);
		quiet(32'h0002_0090, 3'b010, 1'b0, 1'b1);
		quiet(32'h0002_0000, 3'b010, 1'b0, 1'b0);
		quiet(32'h0002_0000, 3'b001, 1'b0, 1'b1);
		// Deglitch select 7 needs 16 cycles above the limit
		wr(`MFR_CTRL_ADDR, 32'h0000_0700);
		current_sense_amp <= 1'b1;
		wait_n(10);
		current_sense_amp <= 1'b0;
		wait_n(12);
		chk_out(STG_DRIVE, 1'b1, 32'h0000_0000);
		current_sense_amp <= 1'b1;
		wait_n(30);
		chk_out(STG_OFF, 1'b0, 32'h0000_0083);
		current_sense_amp <= 1'b0;
		wait_n(8);
		clr();
		wr(`MFR_CTRL_ADDR, 32'h0000_0000);
		warn     <= 1'b1;
		warn_hys <= 1'b0;
		wait_n(10);
		chk_out(STG_DRIVE, 1'b1, 32'h0000_0030);
		wr(`MFR_CTRL_ADDR, 32'h0000_8000);
		wait_n(3);
		chk_out(STG_DRIVE, 1'b0, 32'h0000_00B0);
		clr();
		chk_out(STG_DRIVE, 1'b0, 32'h0000_00B0);
		warn <= 1'b0;
		wait_n(8);
		chk_out(STG_DRIVE, 1'b0, 32'h0000_00B0);
		warn_hys <= 1'b1;
		wait_n(8);
		chk_out(STG_DRIVE, 1'b1, 32'h0000_0030);
		clr();
		chk_out(STG_DRIVE, 1'b1, 32'h0000_0000);
		wr(`MFR_CTRL_ADDR, 32'h0000_4099);
		thermal_shutdown_flag     <= 1'b1;
		tsd_hys <= 1'b0;
		wait_n(10);
		chk_out(STG_OFF, 1'b0, 32'h0000_00D8);
		chk("pump", 32'h0000_0000, {31'h0, cp_en});
		clr();
		chk_out(STG_OFF, 1'b0, 32'h0000_00D8);
		thermal_shutdown_flag <= 1'b0;
		wait_n(8);
		chk_out(STG_OFF, 1'b0, 32'h0000_00D8);
		tsd_hys <= 1'b1;
		wait_n(8);
		chk_out(STG_DRIVE, 1'b1, 32'h0000_0058);
		chk("pump", 32'h0000_0001, {31'h0, cp_en});
		clr();
		chk_out(STG_DRIVE, 1'b1, 32'h0000_0000);
		buck_ocp <= 1'b1;
		wait_n(30);
		buck_ocp <= 1'b0;
		wait_n(8);
		chk("buck pulses", 32'h0000_0000, n_buck);
		buck_ocp <= 1'b1;
		wait_n(48);
		buck_ocp <= 1'b0;
		wait_n(8);
		chk("buck pulses", 32'h0000_0001, n_buck);
		rd_chk("ctrl", `MFR_CTRL_ADDR, 32'h0000_0000);
		test_done();
	end
endmodule
